// [logic/accel_readout_regs.vh]
/*
 Register offsets, field positions, reset values and timing counts
 for the accelerometer register readout block. Definitions only.
*/
`ifndef ACCEL_READOUT_REGS_VH
`define ACCEL_READOUT_REGS_VH

`define ADDR_IDENTIFICATION 8'h00
`define ADDR_FAULT_REPORT 8'h02
`define ADDR_SAMPLE_STATUS 8'h03
`define ADDR_X_RESULT_LOW 8'h12
`define ADDR_X_RESULT_HIGH 8'h13
`define ADDR_Y_RESULT_LOW 8'h14
`define ADDR_Y_RESULT_HIGH 8'h15
`define ADDR_Z_RESULT_LOW 8'h16
`define ADDR_Z_RESULT_HIGH 8'h17
`define ADDR_TIMESTAMP_LOW 8'h18
`define ADDR_TIMESTAMP_MID 8'h19
`define ADDR_TIMESTAMP_HIGH 8'h1A
`define ADDR_IRQ_STATUS 8'h1D
`define ADDR_THERMAL_HIGH 8'h22
`define ADDR_THERMAL_LOW 8'h23
`define ADDR_SAMPLING_CONFIG 8'h40
`define ADDR_FULL_SCALE_SELECT 8'h41
`define ADDR_IRQ_PIN_A_SETUP 8'h53
`define ADDR_IRQ_PIN_B_SETUP 8'h54
`define ADDR_IRQ_PIN_ROUTING 8'h58
`define ADDR_TEST_EXCITATION 8'h6D
`define ADDR_POWER_SAVING_CONFIG 8'h7C
`define ADDR_POWER_SWITCH 8'h7D
`define ADDR_RESET_COMMAND 8'h7E

`define RST_SAMPLING_CONFIG 8'hA8
`define RST_FULL_SCALE_SELECT 8'h01
`define RST_POWER_SAVING_CONFIG 8'h03
`define RST_SAMPLE_STATUS 8'h10
`define RST_ZERO 8'h00

`define MASK_FULL_SCALE_SELECT 8'h03
`define MASK_IRQ_PIN_SETUP 8'h1E
`define MASK_IRQ_PIN_ROUTING 8'h44

`define RESET_COMMAND_BYTE 8'hB6
`define ERR_CODE_NONE 3'h0
`define ERR_CODE_BAD_CONFIG 3'h1
`define BIT_READY 7
`define BIT_FATAL 0
`define ERR_CODE_LSB 2

`define CLK_PERIOD_PS 10000
`define TICK_PERIOD_PS 39062500
`define TICK_CYCLES (`TICK_PERIOD_PS / `CLK_PERIOD_PS)
`define THERMAL_PERIOD_MS 1280
`define THERMAL_CYCLES (`THERMAL_PERIOD_MS * 100000)
`define SOFT_RESET_DELAY_CYCLES 16

`endif

// [logic/accel_register_readout.v]
/*
 Register file of the accelerometer readout: identification, faults,
 status, axis results with read lock, timestamp, interrupt status and
 temperature. Assumes a serial front end (SPI or I2C) already decoded
 into single-cycle read and write strobes with an 8-bit address, and a
 sensor core delivering samples with a one-cycle strobe and temperature as a level.
*/
// Functional notes
// - Lowest address reads a fixed identification byte; writes ignored.
// - Error bits 4:2 report zero for none, one for invalid sampling config.
// - Fatal flag in bit 0 set on boot/power fault, cleared only by resets.
// - Status bit 7 set by new sample, cleared by any axis result read.
// - Each axis is signed 16 bits, low byte then high byte, x y z ascending.
// - Reading a low byte freezes that axis high byte until it is read.
// - Free-running 24-bit timestamp, low byte steps every 3906 cycles (39.06 us), wraps.
// - Timestamp seen as low, mid, high bytes, each carrying from below.
// - Interrupt status bit 7 set by new sample, cleared by reading it.
// - Temperature is 11-bit signed: 10:3 in high byte, 2:0 in low byte top.
// - Temperature registers refresh once every 1.28 s, holding between.
// - Eight-bit registers in an 8-bit address space behind own select.
// - Writing the reset command byte restores defaults after a delay.
`timescale 1ns/100ps
`include "accel_readout_regs.vh"

module accel_register_readout #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter THERMAL_CYCLES = `THERMAL_CYCLES,
  parameter [7:0] IDENTIFICATION_BYTE = 8'h5A
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire resetn_i,
  // Register access from the serial front end
  input wire reg_sel_i,
  input wire reg_rd_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // Sensor core
  input wire sample_valid_i,
  input wire [15:0] sample_x_i,
  input wire [15:0] sample_y_i,
  input wire [15:0] sample_z_i,
  input wire [10:0] thermal_i,
  input wire core_fault_i,
  // Configuration and data-ready flag towards the core and pin logic
  output reg [7:0] sampling_config_o,
  output reg [1:0] full_scale_o,
  output reg [7:0] test_excitation_o,
  output reg [7:0] power_saving_o,
  output reg [7:0] power_switch_o,
  output reg [7:0] irq_pin_a_setup_o,
  output reg [7:0] irq_pin_b_setup_o,
  output reg route_ready_to_pin_a_o,
  output reg route_ready_to_pin_b_o,
  output reg data_ready_o
);

  localparam ST_RUN = 2'b01;
  localparam ST_SRST = 2'b10;

  // Counter end points sized once here, so no compare silently truncates
  localparam [31:0] SRST_LAST = `SOFT_RESET_DELAY_CYCLES - 1;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  localparam [31:0] THERM_LAST = THERMAL_CYCLES - 1;

  reg rst_meta_r;
  reg rst_sync_r;
  reg [1:0] state_r;
  reg [4:0] srst_cnt_r;
  reg [7:0] conf_r;
  reg [7:0] range_r;
  reg [7:0] pin_a_r;
  reg [7:0] pin_b_r;
  reg [7:0] route_r;
  reg [7:0] selftest_r;
  reg [7:0] pwr_conf_r;
  reg [7:0] pwr_ctrl_r;
  reg fatal_r;
  reg drdy_r;
  reg int_drdy_r;
  reg [15:0] ax_r [0:2];
  reg [7:0] high_hold_r [0:2];
  reg [2:0] lock_r;
  reg [23:0] stamp_r;
  reg [31:0] tick_cnt_r;
  reg [31:0] therm_cnt_r;
  reg [10:0] therm_r;
  reg [7:0] rdata_nxt;
  reg [2:0] err_code;
  integer i;

  wire rd = reg_sel_i & reg_rd_i;
  wire wr = reg_sel_i & reg_wr_i & (state_r == ST_RUN);
  wire soft_rst = wr & (reg_addr_i == `ADDR_RESET_COMMAND) & (reg_wdata_i == `RESET_COMMAND_BYTE);
  wire cfg_reset = (state_r == ST_SRST) & (srst_cnt_r == 5'h00);
  wire axis_rd = rd & (reg_addr_i >= `ADDR_X_RESULT_LOW) & (reg_addr_i <= `ADDR_Z_RESULT_HIGH);

  // Axis index of a result address
  function [1:0] axis_of;
    input [7:0] addr;
    reg [7:0] offset;
    begin
      offset = addr - `ADDR_X_RESULT_LOW;
      axis_of = offset[2:1];
    end
  endfunction

  // Valid sampling config: bandwidth 8..A, rate 5..C
  function config_ok;
    input [7:0] c;
    begin
      config_ok = (c[7:4] >= 4'h8) && (c[7:4] <= 4'hA) && (c[3:0] >= 4'h5) && (c[3:0] <= 4'hC);
    end
  endfunction

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always @* begin
    err_code = config_ok(conf_r) ? `ERR_CODE_NONE : `ERR_CODE_BAD_CONFIG;
  end

  // Read mux; reserved addresses and bits yield zero
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      `ADDR_IDENTIFICATION: rdata_nxt = IDENTIFICATION_BYTE;
      `ADDR_FAULT_REPORT: rdata_nxt = {3'h0, err_code, 1'b0, fatal_r};
      // Bit 4 keeps its reset one; only bit 7 is live
      `ADDR_SAMPLE_STATUS: rdata_nxt = {drdy_r, 7'h00} | `RST_SAMPLE_STATUS;
      `ADDR_X_RESULT_LOW: rdata_nxt = ax_r[0][7:0];
      `ADDR_Y_RESULT_LOW: rdata_nxt = ax_r[1][7:0];
      `ADDR_Z_RESULT_LOW: rdata_nxt = ax_r[2][7:0];
      `ADDR_X_RESULT_HIGH: rdata_nxt = lock_r[0] ? high_hold_r[0] : ax_r[0][15:8];
      `ADDR_Y_RESULT_HIGH: rdata_nxt = lock_r[1] ? high_hold_r[1] : ax_r[1][15:8];
      `ADDR_Z_RESULT_HIGH: rdata_nxt = lock_r[2] ? high_hold_r[2] : ax_r[2][15:8];
      `ADDR_TIMESTAMP_LOW: rdata_nxt = stamp_r[7:0];
      `ADDR_TIMESTAMP_MID: rdata_nxt = stamp_r[15:8];
      `ADDR_TIMESTAMP_HIGH: rdata_nxt = stamp_r[23:16];
      `ADDR_IRQ_STATUS: rdata_nxt = {int_drdy_r, 7'h00};
      `ADDR_THERMAL_HIGH: rdata_nxt = therm_r[10:3];
      `ADDR_THERMAL_LOW: rdata_nxt = {therm_r[2:0], 5'h00};
      `ADDR_SAMPLING_CONFIG: rdata_nxt = conf_r;
      `ADDR_FULL_SCALE_SELECT: rdata_nxt = range_r;
      `ADDR_IRQ_PIN_A_SETUP: rdata_nxt = pin_a_r;
      `ADDR_IRQ_PIN_B_SETUP: rdata_nxt = pin_b_r;
      `ADDR_IRQ_PIN_ROUTING: rdata_nxt = route_r;
      `ADDR_TEST_EXCITATION: rdata_nxt = selftest_r;
      `ADDR_POWER_SAVING_CONFIG: rdata_nxt = pwr_conf_r;
      `ADDR_POWER_SWITCH: rdata_nxt = pwr_ctrl_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Soft reset sequencer; host writes are ignored while it runs
  // Dropping writes avoids a config half applied then overwritten
  always @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= ST_RUN;
      srst_cnt_r <= 5'h00;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (soft_rst) begin
            state_r <= ST_SRST;
            srst_cnt_r <= SRST_LAST[4:0];
          end
        end
        ST_SRST: begin
          if (srst_cnt_r == 5'h00) begin
            state_r <= ST_RUN;
          end else begin
            srst_cnt_r <= srst_cnt_r - 5'h01;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Writable configuration; read-only registers have no write path
  always @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      conf_r <= `RST_SAMPLING_CONFIG;
      range_r <= `RST_FULL_SCALE_SELECT;
      pin_a_r <= `RST_ZERO;
      pin_b_r <= `RST_ZERO;
      route_r <= `RST_ZERO;
      selftest_r <= `RST_ZERO;
      pwr_conf_r <= `RST_POWER_SAVING_CONFIG;
      pwr_ctrl_r <= `RST_ZERO;
    end else if (cfg_reset) begin
      conf_r <= `RST_SAMPLING_CONFIG;
      range_r <= `RST_FULL_SCALE_SELECT;
      pin_a_r <= `RST_ZERO;
      pin_b_r <= `RST_ZERO;
      route_r <= `RST_ZERO;
      selftest_r <= `RST_ZERO;
      pwr_conf_r <= `RST_POWER_SAVING_CONFIG;
      pwr_ctrl_r <= `RST_ZERO;
    end else if (wr) begin
      case (reg_addr_i)
        `ADDR_SAMPLING_CONFIG: conf_r <= reg_wdata_i;
        `ADDR_FULL_SCALE_SELECT: range_r <= reg_wdata_i & `MASK_FULL_SCALE_SELECT;
        `ADDR_IRQ_PIN_A_SETUP: pin_a_r <= reg_wdata_i & `MASK_IRQ_PIN_SETUP;
        `ADDR_IRQ_PIN_B_SETUP: pin_b_r <= reg_wdata_i & `MASK_IRQ_PIN_SETUP;
        `ADDR_IRQ_PIN_ROUTING: route_r <= reg_wdata_i & `MASK_IRQ_PIN_ROUTING;
        `ADDR_TEST_EXCITATION: selftest_r <= reg_wdata_i;
        `ADDR_POWER_SAVING_CONFIG: pwr_conf_r <= reg_wdata_i;
        `ADDR_POWER_SWITCH: pwr_ctrl_r <= reg_wdata_i;
        default: conf_r <= conf_r;
      endcase
    end
  end

  // Flags: a new sample in the same cycle as a clearing read wins
  // Losing a sample event is worse than a spare ready report
  always @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      fatal_r <= 1'b0;
      drdy_r <= 1'b0;
      int_drdy_r <= 1'b0;
    end else begin
      if (cfg_reset) begin
        fatal_r <= 1'b0;
      end else if (core_fault_i) begin
        fatal_r <= 1'b1;
      end
      if (sample_valid_i) begin
        drdy_r <= 1'b1;
      end else if (axis_rd) begin
        drdy_r <= 1'b0;
      end
      if (sample_valid_i) begin
        int_drdy_r <= 1'b1;
      end else if (rd && reg_addr_i == `ADDR_IRQ_STATUS) begin
        int_drdy_r <= 1'b0;
      end
    end
  end

  // Axis results with high-byte lock
  // Lock is per axis, so interleaved axis reads stay coherent
  // Limitation: a high read without a low read is never locked
  always @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      lock_r <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        ax_r[i] <= 16'h0000;
        high_hold_r[i] <= 8'h00;
      end
    end else begin
      if (sample_valid_i) begin
        ax_r[0] <= sample_x_i;
        ax_r[1] <= sample_y_i;
        ax_r[2] <= sample_z_i;
      end
      if (axis_rd) begin
        if (reg_addr_i[0] == 1'b0) begin
          lock_r[axis_of(reg_addr_i)] <= 1'b1;
          high_hold_r[axis_of(reg_addr_i)] <= ax_r[axis_of(reg_addr_i)][15:8];
        end else begin
          lock_r[axis_of(reg_addr_i)] <= 1'b0;
        end
      end
    end
  end

  // Timestamp and temperature; counters keep running through soft reset
  // Host time base stays continuous across a soft reset
  // Tick period is rounded down to whole clock cycles
  always @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      stamp_r <= 24'h000000;
      tick_cnt_r <= 32'h00000000;
      therm_cnt_r <= 32'h00000000;
      therm_r <= 11'h000;
    end else begin
      if (tick_cnt_r == TICK_LAST) begin
        tick_cnt_r <= 32'h00000000;
        stamp_r <= stamp_r + 24'h000001;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h00000001;
      end
      if (therm_cnt_r == THERM_LAST) begin
        therm_cnt_r <= 32'h00000000;
        therm_r <= thermal_i;
      end else begin
        therm_cnt_r <= therm_cnt_r + 32'h00000001;
      end
    end
  end

  // Registered outputs
  // One cycle of latency buys glitch-free pins
  always @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
      sampling_config_o <= `RST_SAMPLING_CONFIG;
      full_scale_o <= 2'h1;
      test_excitation_o <= 8'h00;
      power_saving_o <= `RST_POWER_SAVING_CONFIG;
      power_switch_o <= 8'h00;
      irq_pin_a_setup_o <= 8'h00;
      irq_pin_b_setup_o <= 8'h00;
      route_ready_to_pin_a_o <= 1'b0;
      route_ready_to_pin_b_o <= 1'b0;
      data_ready_o <= 1'b0;
    end else begin
      reg_rdata_o <= rd ? rdata_nxt : 8'h00;
      reg_rvalid_o <= rd;
      sampling_config_o <= conf_r;
      full_scale_o <= range_r[1:0];
      test_excitation_o <= selftest_r;
      power_saving_o <= pwr_conf_r;
      power_switch_o <= pwr_ctrl_r;
      irq_pin_a_setup_o <= pin_a_r;
      irq_pin_b_setup_o <= pin_b_r;
      route_ready_to_pin_a_o <= route_r[2];
      route_ready_to_pin_b_o <= route_r[6];
      data_ready_o <= int_drdy_r;
    end
  end

endmodule

// [bench/accel_readout_checker_assertions.sv]
/* Checker for the readout block, bound to its top module ports.
 Assumes no request before the third edge after reset release. */
`timescale 1ns/100ps
module accel_readout_checker #(
  parameter [7:0] IDENTIFICATION_BYTE = 8'h5A
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire reg_sel_i,
  input wire reg_rd_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire sample_valid_i,
  input wire [1:0] full_scale_o,
  input wire route_ready_to_pin_a_o,
  input wire data_ready_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire rd = reg_sel_i && reg_rd_i;
  wire wr = reg_sel_i && reg_wr_i;
  property p_answer; rd |=> reg_rvalid_o; endproperty
  a_answer: assert property (p_answer) else $error("no read answer");
  property p_quiet; !rd |=> !reg_rvalid_o && reg_rdata_o == 8'h00; endproperty
  a_quiet: assert property (p_quiet) else $error("read bus not idle");
  property p_ident; rd && reg_addr_i == 8'h00 |=> reg_rdata_o == IDENTIFICATION_BYTE; endproperty
  a_ident: assert property (p_ident) else $error("bad identification");
  property p_hole; rd && reg_addr_i == 8'h01 |=> reg_rdata_o == 8'h00; endproperty
  a_hole: assert property (p_hole) else $error("reserved read not zero");
  property p_ready_set; sample_valid_i |-> ##[1:2] data_ready_o; endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not raised");
  property p_ready_cause; $rose(data_ready_o) |-> $past(sample_valid_i) || $past(sample_valid_i, 2); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without sample");
  property p_range; !$stable(full_scale_o) |-> $past(wr && reg_addr_i == 8'h41, 2) || full_scale_o == 2'h1;
  endproperty
  a_range: assert property (p_range) else $error("range changed unasked");
  property p_route; !$stable(route_ready_to_pin_a_o) |-> $past(wr && reg_addr_i == 8'h58, 2) ||
    !route_ready_to_pin_a_o; endproperty
  a_route: assert property (p_route) else $error("routing changed unasked");
  c_ident: cover property (rd && reg_addr_i == 8'h00);
  c_sample: cover property (sample_valid_i);
  c_reset_cmd: cover property (wr && reg_addr_i == 8'h7E);
endmodule
bind accel_register_readout accel_readout_checker #(.IDENTIFICATION_BYTE(IDENTIFICATION_BYTE)) i_chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_sel_i(reg_sel_i), .reg_rd_i(reg_rd_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .sample_valid_i(sample_valid_i), .full_scale_o(full_scale_o),
  .route_ready_to_pin_a_o(route_ready_to_pin_a_o), .data_ready_o(data_ready_o));

// [bench/host_model.sv]
/* Host side model: single register reads and writes.
 Assumes a read answer exactly one cycle after the read edge. */
`timescale 1ns/100ps
module host_model (
  input wire sys_clk_i,
  output logic reg_sel_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire [7:0] reg_rdata_i,
  input wire reg_rvalid_i
);
  initial begin
    reg_sel_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // Host scaling in integer milli units; to_millideg is exact, to_milli_g truncates toward zero
  function automatic int to_millideg(input logic [7:0] hi, input logic [7:0] lo);
    logic signed [10:0] c;
    c = {hi, lo[7:5]};
    return c * 125 + 23000;
  endfunction
  function automatic int to_milli_g(input logic signed [15:0] c, input logic [1:0] r);
    return (c * 1000 * (2 << r)) / 32768;
  endfunction
  // Released lines flip so stale values never look valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_sel_o <= 1'b1;
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge sys_clk_i);
    reg_sel_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_sel_o <= 1'b1;
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= v;
    @(posedge sys_clk_i);
    reg_sel_o <= 1'b0;
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~v;
  endtask
endmodule

// [bench/accel_register_readout_tb.sv]
/* Testbench for the register readout block.
 Assumes host_model drives the register strobes; short tick counts. */
`timescale 1ns/100ps
module accel_register_readout_tb;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sel, rd, wr, rvalid, sv = 1'b0, fault = 1'b0, route_a, drdy_out;
  logic [7:0] addr, wdata, rdata, d, t0;
  logic [15:0] x = 16'h0, y = 16'h0, z = 16'h0;
  logic [10:0] therm = 11'h7F9;
  logic [1:0] range;
  integer failures = 0;
  integer compares = 0;
  logic [15:0] rows [15] = '{16'h005A, 16'h0100, 16'h0200, 16'h0310, 16'h1200, 16'h1700, 16'h1D00, 16'h40A8,
    16'h4101, 16'h5300, 16'h5800, 16'h7C03, 16'h7D00, 16'h3000, 16'hFF00};
  always #5 sys_clk_i = ~sys_clk_i;
  host_model i_host (.sys_clk_i(sys_clk_i), .reg_sel_o(sel), .reg_rd_o(rd), .reg_wr_o(wr), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  // Short counts keep the run brief; identification value is arbitrary
  accel_register_readout #(.TICK_CYCLES(4), .THERMAL_CYCLES(50), .IDENTIFICATION_BYTE(8'h5A)) i_dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_sel_i(sel), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .sample_valid_i(sv), .sample_x_i(x), .sample_y_i(y), .sample_z_i(z), .thermal_i(therm),
    .core_fault_i(fault), .sampling_config_o(), .full_scale_o(range), .test_excitation_o(),
    .power_saving_o(), .power_switch_o(), .irq_pin_a_setup_o(), .irq_pin_b_setup_o(),
    .route_ready_to_pin_a_o(route_a), .route_ready_to_pin_b_o(), .data_ready_o(drdy_out));
  task chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch reg %h expected %h seen %h", a, e, g);
    end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk(a, e, d);
  endtask
  task sample(input logic [15:0] nx);
    @(posedge sys_clk_i);
    x <= nx;
    y <= 16'h8001;
    z <= 16'hFFFF;
    sv <= 1'b1;
    @(posedge sys_clk_i);
    sv <= 1'b0;
  endtask
  task conclude;
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    foreach (rows[i]) rc(rows[i][15:8], rows[i][7:0]);
    i_host.wr(8'h00, 8'hFF);
    i_host.wr(8'h12, 8'hFF);
    i_host.wr(8'h41, 8'hFF);
    i_host.wr(8'h58, 8'hFF);
    i_host.wr(8'h53, 8'hFF);
    rc(8'h00, 8'h5A);
    rc(8'h12, 8'h00);
    rc(8'h41, 8'h03);
    rc(8'h58, 8'h44);
    rc(8'h53, 8'h1E);
    chk(8'h41, 8'h03, {6'h00, range});
    chk(8'h58, 8'h01, {7'h00, route_a});
    sample(16'h1234);
    rc(8'h03, 8'h90);
    chk(8'h1D, 8'h01, {7'h00, drdy_out});
    rc(8'h1D, 8'h80);
    rc(8'h1D, 8'h00);
    chk(8'h1D, 8'h00, {7'h00, drdy_out});
    rc(8'h12, 8'h34);
    sample(16'hABCD);
    rc(8'h13, 8'h12);
    rc(8'h03, 8'h10);
    rc(8'h14, 8'h01);
    rc(8'h15, 8'h80);
    compares++;
    if (i_host.to_milli_g(16'h8001, range) != -15999) begin
      failures++;
      $display("mismatch milli_g expected -15999 seen %0d", i_host.to_milli_g(16'h8001, range));
    end
    rc(8'h16, 8'hFF);
    rc(8'h17, 8'hFF);
    rc(8'h12, 8'hCD);
    rc(8'h13, 8'hAB);
    i_host.rd(8'h18, t0);
    repeat (38) @(posedge sys_clk_i);
    rc(8'h18, t0 + 8'h0A);
    i_host.rd(8'h19, t0);
    repeat (1022) @(posedge sys_clk_i);
    rc(8'h19, t0 + 8'h01);
    rc(8'h22, 8'hFF);
    rc(8'h23, 8'h20);
    i_host.rd(8'h22, t0);
    i_host.rd(8'h23, d);
    compares++;
    if (i_host.to_millideg(t0, d) != 22125) begin
      failures++;
      $display("mismatch millideg expected 22125 seen %0d", i_host.to_millideg(t0, d));
    end
    i_host.wr(8'h40, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    rc(8'h02, 8'h04);
    @(posedge sys_clk_i);
    fault <= 1'b1;
    @(posedge sys_clk_i);
    fault <= 1'b0;
    rc(8'h02, 8'h05);
    i_host.wr(8'h7E, 8'hB6);
    repeat (20) @(posedge sys_clk_i);
    rc(8'h02, 8'h00);
    rc(8'h40, 8'hA8);
    rc(8'h41, 8'h01);
    i_host.wr(8'h41, 8'h02);
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk(8'h41, 8'h01, {6'h00, range});
    rc(8'h41, 8'h01);
    rc(8'h03, 8'h10);
    conclude();
  end
endmodule
